// File: core/dcq_pkg.sv
// Shared constants and types of the dual-clock queue with its flag logic.
// What this block does
// - Own-domain flags update on the request edge.
// - Opposite-domain flags follow after synchroniser delay.
// - Extra synchroniser stage adds one receiving cycle.
// - Fall-through empty clears one read later.
// - Fall-through data, valid and empty change together.
// - Fall-through almost-empty keeps standard latency.
// - Programmable flags exist only in threshold modes.
// - Programmable full uses write view, empty read view.
// - Single full threshold asserts and negates alike.
// - Dual full negates below separate negate threshold.
// - Single empty threshold asserts and negates alike.
// - Dual empty negates above separate negate threshold.
// - Queue cleared by asynchronous active-high reset.
// - Writes during reset ignored, accepted after.
// - Reset leaves read data untouched.
// - Separate word counts per domain.
// - Counts are log2 depth wide, wrapping.
// - Latency zero means same sampling edge.
// - Write when full ignored, overflow follows.
// - Read when empty ignored, underflow follows.
package dcq_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] DCQ_OFF_FULL_THR = 8'h00;
  localparam logic [7:0] DCQ_OFF_STATUS = 8'h04;

  // Field positions inside the registers.
  localparam int DCQ_THR_ASSERT_LSB = 0;
  localparam int DCQ_THR_NEGATE_LSB = 16;
  localparam int DCQ_STAT_FLAGS_LSB = 0;
  localparam int DCQ_STAT_COUNT_LSB = 8;

  // Bus encodings and answers.
  localparam logic [1:0] DCQ_HTRANS_NONSEQ = 2'h2;
  localparam logic DCQ_HRESP_OKAY = 1'h0;
  localparam int DCQ_ADDR_BITS = 8;

  // Synchroniser depth without the extra stage.
  localparam int DCQ_BASE_SYNC_STAGES = 2;

  typedef enum logic [1:0]
  {
    DCQ_PROG_OFF = 2'b00,
    DCQ_PROG_SINGLE = 2'b01,
    DCQ_PROG_DUAL = 2'b10
  } dcq_prog_mode_type;

  typedef struct packed
  {
    logic full;
    logic almost_full;
    logic prog_full;
    logic wr_ack;
    logic overflow;
  } dcq_wr_flags_type;

  typedef struct packed
  {
    logic empty;
    logic almost_empty;
    logic prog_empty;
    logic rd_valid;
    logic underflow;
  } dcq_rd_flags_type;

  localparam dcq_wr_flags_type DCQ_WR_FLAGS_RESET = '{default: 1'b0};
  localparam dcq_rd_flags_type DCQ_RD_FLAGS_RESET = '{empty: 1'b1, almost_empty: 1'b1,
                                                     prog_empty: 1'b0, rd_valid: 1'b0,
                                                     underflow: 1'b0};

endpackage : dcq_pkg

// File: core/dcq_top.sv
// Dual-clock queue with cross-domain flags, fall-through option and a bus slave.
`timescale 1ns/1ns
`default_nettype none

module dcq_top
  import dcq_pkg::*;
#(
  parameter int DATA_WIDTH = 8,
  parameter int DEPTH = 16,
  parameter bit FALL_THROUGH_PRESENTATION = 1'b0,
  parameter bit EXTRA_SYNC_STAGE = 1'b0,
  parameter dcq_prog_mode_type PROG_FULL_MODE = DCQ_PROG_SINGLE,
  parameter dcq_prog_mode_type PROG_EMPTY_MODE = DCQ_PROG_SINGLE,
  parameter int PROG_FULL_ASSERT = 12,
  parameter int PROG_FULL_NEGATE = 10,
  parameter int PROG_EMPTY_ASSERT = 2,
  parameter int PROG_EMPTY_NEGATE = 4
)
(
  // Clocks and resets; hclk is both the write clock and the bus clock.
  input wire logic hclk,
  input wire logic rd_clk,
  input wire logic queue_rst,
  input wire logic hresetn,
  // Write side.
  input wire logic wr_en,
  input wire logic [DATA_WIDTH-1:0] wdata,
  output var dcq_wr_flags_type wr_flags,
  output logic [$clog2(DEPTH)-1:0] wr_count,
  // Read side.
  input wire logic rd_en,
  output logic [DATA_WIDTH-1:0] rdata,
  output var dcq_rd_flags_type rd_flags,
  output logic [$clog2(DEPTH)-1:0] rd_count,
  // Register bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int SYNC = DCQ_BASE_SYNC_STAGES + int'(EXTRA_SYNC_STAGE);

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--)
    begin
      b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i + 1]);
    end
    gray2bin = b;
  endfunction : gray2bin

  typedef struct packed
  {
    logic [PW-1:0] wbin;
    logic [PW-1:0] wgray;
    logic [AW-1:0] count;
    dcq_wr_flags_type flags;
  } dcq_wr_state_type;

  typedef struct packed
  {
    logic [PW-1:0] rbin;
    logic [PW-1:0] rgray;
    logic [AW-1:0] count;
    logic stocked;
    dcq_rd_flags_type flags;
  } dcq_rd_state_type;

  typedef struct packed
  {
    logic dph_wr;
    logic [DCQ_ADDR_BITS-1:0] dph_addr;
    logic [PW-1:0] full_assert;
    logic [PW-1:0] full_negate;
    logic [31:0] rd_word;
    logic ready;
    logic resp;
  } dcq_bus_state_type;

  logic [DATA_WIDTH-1:0] mem [DEPTH];

  dcq_wr_state_type w;
  dcq_wr_state_type next_w;
  dcq_rd_state_type r;
  dcq_rd_state_type next_r;
  dcq_bus_state_type b;
  dcq_bus_state_type next_b;

  // Gray pointers crossing the domains; stage 0 feeds only stage 1.
  logic [SYNC-1:0][PW-1:0] wsync;
  logic [SYNC-1:0][PW-1:0] rsync;

  logic wr_ok;
  logic [PW-1:0] rptr_w;
  logic [PW-1:0] used_w;
  logic rd_ok;
  logic rd_load;
  logic [PW-1:0] wptr_r;
  logic [PW-1:0] left_r;

  localparam dcq_wr_state_type WR_RESET = '{wbin: '0, wgray: '0, count: '0,
                                            flags: DCQ_WR_FLAGS_RESET};
  localparam dcq_rd_state_type RD_RESET = '{rbin: '0, rgray: '0, count: '0, stocked: 1'b0,
                                            flags: DCQ_RD_FLAGS_RESET};

  // Write domain.
  always_comb
  begin
    next_w = w;
    rptr_w = gray2bin(rsync[SYNC-1]);
    wr_ok = wr_en && !w.flags.full;
    next_w.wbin = w.wbin + PW'(wr_ok);
    next_w.wgray = bin2gray(next_w.wbin);
    used_w = next_w.wbin - rptr_w;
    next_w.count = used_w[AW-1:0];
    next_w.flags.full = (used_w == PW'(DEPTH));
    next_w.flags.almost_full = (used_w >= PW'(DEPTH - 1));
    next_w.flags.wr_ack = wr_ok;
    next_w.flags.overflow = wr_en && w.flags.full;
    case (PROG_FULL_MODE)
      DCQ_PROG_SINGLE:
      begin
        next_w.flags.prog_full = (used_w >= b.full_assert);
      end
      DCQ_PROG_DUAL:
      begin
        if (used_w >= b.full_assert)
        begin
          next_w.flags.prog_full = 1'b1;
        end
        else if (used_w < b.full_negate)
        begin
          next_w.flags.prog_full = 1'b0;
        end
      end
      default:
      begin
        next_w.flags.prog_full = 1'b0;
      end
    endcase
  end

  // Pointers hold their reset value for as long as the reset stands.
  always_ff @(posedge hclk or posedge queue_rst)
  begin
    if (queue_rst)
    begin
      w <= WR_RESET;
      rsync <= '0;
    end
    else
    begin
      w <= next_w;
      rsync <= {rsync[SYNC-2:0], r.rgray};
    end
  end

  // Storage carries no reset; it is written on every wr_ok, even while queue_rst holds the pointer.
  always_ff @(posedge hclk)
  begin
    if (wr_ok)
    begin
      mem[w.wbin[AW-1:0]] <= wdata;
    end
  end

  // Read domain.
  always_comb
  begin
    next_r = r;
    rd_load = 1'b0;
    wptr_r = gray2bin(wsync[SYNC-1]);
    if (FALL_THROUGH_PRESENTATION)
    begin
      rd_ok = rd_en && r.flags.rd_valid;
    end
    else
    begin
      rd_ok = rd_en && !r.flags.empty;
    end
    next_r.rbin = r.rbin + PW'(rd_ok);
    next_r.rgray = bin2gray(next_r.rbin);
    left_r = wptr_r - next_r.rbin;
    next_r.count = left_r[AW-1:0];
    next_r.stocked = (left_r != '0);
    next_r.flags.almost_empty = (left_r <= PW'(1));
    next_r.flags.underflow = rd_en && r.flags.empty;
    if (FALL_THROUGH_PRESENTATION)
    begin
      // Presenting a word while none is valid waits for the stock seen one edge earlier.
      if (rd_ok)
      begin
        next_r.flags.rd_valid = (left_r != '0);
      end
      else
      begin
        next_r.flags.rd_valid = r.flags.rd_valid || r.stocked;
      end
      rd_load = next_r.flags.rd_valid && (rd_ok || !r.flags.rd_valid);
      next_r.flags.empty = !next_r.flags.rd_valid;
    end
    else
    begin
      next_r.flags.rd_valid = rd_ok;
      rd_load = rd_ok;
      next_r.flags.empty = (left_r == '0);
    end
    case (PROG_EMPTY_MODE)
      DCQ_PROG_SINGLE:
      begin
        next_r.flags.prog_empty = (left_r <= PW'(PROG_EMPTY_ASSERT));
      end
      DCQ_PROG_DUAL:
      begin
        if (left_r <= PW'(PROG_EMPTY_ASSERT))
        begin
          next_r.flags.prog_empty = 1'b1;
        end
        else if (left_r > PW'(PROG_EMPTY_NEGATE))
        begin
          next_r.flags.prog_empty = 1'b0;
        end
      end
      default:
      begin
        next_r.flags.prog_empty = 1'b0;
      end
    endcase
  end

  always_ff @(posedge rd_clk or posedge queue_rst)
  begin
    if (queue_rst)
    begin
      r <= RD_RESET;
      wsync <= '0;
    end
    else
    begin
      r <= next_r;
      wsync <= {wsync[SYNC-2:0], w.wgray};
    end
  end

  // Read data has no reset so that a reset leaves the last word in place.
  always_ff @(posedge rd_clk)
  begin
    if (rd_load)
    begin
      if (FALL_THROUGH_PRESENTATION)
      begin
        rdata <= mem[next_r.rbin[AW-1:0]];
      end
      else
      begin
        rdata <= mem[r.rbin[AW-1:0]];
      end
    end
  end

  // Bus slave: zero wait states, read word prepared in the address phase.
  always_comb
  begin
    next_b = b;
    next_b.ready = 1'b1;
    next_b.resp = DCQ_HRESP_OKAY;
    if (b.dph_wr && (b.dph_addr == DCQ_OFF_FULL_THR))
    begin
      next_b.full_assert = hwdata[DCQ_THR_ASSERT_LSB +: PW];
      next_b.full_negate = hwdata[DCQ_THR_NEGATE_LSB +: PW];
    end
    next_b.dph_wr = 1'b0;
    if (hsel && hready && (htrans == DCQ_HTRANS_NONSEQ))
    begin
      next_b.dph_wr = hwrite;
      next_b.dph_addr = haddr[DCQ_ADDR_BITS-1:0];
      // Built from the updated fields so that read-after-write sees new data.
      next_b.rd_word = '0;
      if (!hwrite)
      begin
        case (haddr[DCQ_ADDR_BITS-1:0])
          DCQ_OFF_FULL_THR:
          begin
            next_b.rd_word[DCQ_THR_ASSERT_LSB +: PW] = next_b.full_assert;
            next_b.rd_word[DCQ_THR_NEGATE_LSB +: PW] = next_b.full_negate;
          end
          DCQ_OFF_STATUS:
          begin
            next_b.rd_word[DCQ_STAT_FLAGS_LSB +: $bits(dcq_wr_flags_type)] = w.flags;
            next_b.rd_word[DCQ_STAT_COUNT_LSB +: AW] = w.count;
          end
          default:
          begin
            next_b.rd_word = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      b <= '{dph_wr: 1'b0, dph_addr: '0, full_assert: PW'(PROG_FULL_ASSERT),
             full_negate: PW'(PROG_FULL_NEGATE), rd_word: '0, ready: 1'b1,
             resp: DCQ_HRESP_OKAY};
    end
    else
    begin
      b <= next_b;
    end
  end

  assign wr_flags = w.flags;
  assign wr_count = w.count;
  assign rd_flags = r.flags;
  assign rd_count = r.count;
  assign hreadyout = b.ready;
  assign hrdata = b.rd_word;
  assign hresp = b.resp;

endmodule : dcq_top

`default_nettype wire

// File: tb/dcq_monitor.sv
// Concurrent checks on the ports of the dual-clock queue.
`timescale 1ns/1ns
`default_nettype none

module dcq_monitor
  import dcq_pkg::*;
#(
  parameter int DATA_WIDTH = 8,
  parameter int DEPTH = 16,
  parameter bit FALL_THROUGH_PRESENTATION = 1'b0,
  parameter dcq_prog_mode_type PROG_FULL_MODE = DCQ_PROG_SINGLE,
  parameter dcq_prog_mode_type PROG_EMPTY_MODE = DCQ_PROG_SINGLE,
  parameter int PROG_FULL_ASSERT = 12,
  parameter int PROG_FULL_NEGATE = 10,
  parameter int PROG_EMPTY_ASSERT = 2,
  parameter int PROG_EMPTY_NEGATE = 4
)
(
  // Clocks and reset.
  input wire logic hclk,
  input wire logic rd_clk,
  input wire logic queue_rst,
  // Write side.
  input wire logic wr_en,
  input wire dcq_wr_flags_type wr_flags,
  input wire logic [$clog2(DEPTH)-1:0] wr_count,
  // Read side.
  input wire logic rd_en,
  input wire logic [DATA_WIDTH-1:0] rdata,
  input wire dcq_rd_flags_type rd_flags,
  input wire logic [$clog2(DEPTH)-1:0] rd_count
);
  write_ack_a: assert property (@(posedge hclk) disable iff (queue_rst)
    wr_en && !wr_flags.full |=> wr_flags.wr_ack && !wr_flags.overflow)
    else $error("write not acknowledged");
  overflow_pulse_a: assert property (@(posedge hclk) disable iff (queue_rst)
    wr_en && wr_flags.full |=> wr_flags.overflow && !wr_flags.wr_ack)
    else $error("overflow missing");
  // Between the two dual thresholds the flag keeps its history, so only the outside is checked.
  prog_full_level_a: assert property (@(posedge hclk) disable iff (queue_rst)
    !wr_flags.full && (PROG_FULL_MODE != DCQ_PROG_DUAL || wr_count >= PROG_FULL_ASSERT ||
      wr_count < PROG_FULL_NEGATE) |-> wr_flags.prog_full == (wr_count >= PROG_FULL_ASSERT))
    else $error("programmable full wrong");
  full_count_wrap_a: assert property (@(posedge hclk) disable iff (queue_rst)
    wr_flags.full |-> wr_count == 0)
    else $error("full count not zero");
  underflow_pulse_a: assert property (@(posedge rd_clk) disable iff (queue_rst)
    rd_en && rd_flags.empty |=> rd_flags.underflow &&
      (FALL_THROUGH_PRESENTATION || !rd_flags.rd_valid))
    else $error("underflow missing");
  read_valid_a: assert property (@(posedge rd_clk) disable iff (queue_rst)
    !FALL_THROUGH_PRESENTATION && rd_en && !rd_flags.empty |=>
      rd_flags.rd_valid && !rd_flags.underflow)
    else $error("read valid missing");
  prog_empty_level_a: assert property (@(posedge rd_clk) disable iff (queue_rst)
    rd_count != 0 && (PROG_EMPTY_MODE != DCQ_PROG_DUAL || rd_count <= PROG_EMPTY_ASSERT ||
      rd_count > PROG_EMPTY_NEGATE) |-> rd_flags.prog_empty == (rd_count <= PROG_EMPTY_ASSERT))
    else $error("programmable empty wrong");
  read_data_hold_a: assert property (@(posedge rd_clk) disable iff (queue_rst)
    !FALL_THROUGH_PRESENTATION && !(rd_en && !rd_flags.empty) |=> $stable(rdata))
    else $error("read data moved without a read");
  next_word_a: assert property (@(posedge rd_clk) disable iff (queue_rst)
    FALL_THROUGH_PRESENTATION && rd_en && rd_flags.rd_valid && rd_count > 1 |=>
      rd_flags.rd_valid && !rd_flags.empty)
    else $error("next word not presented");
endmodule : dcq_monitor

bind dcq_top dcq_monitor #(.DATA_WIDTH(DATA_WIDTH), .DEPTH(DEPTH),
  .FALL_THROUGH_PRESENTATION(FALL_THROUGH_PRESENTATION), .PROG_FULL_MODE(PROG_FULL_MODE),
  .PROG_EMPTY_MODE(PROG_EMPTY_MODE), .PROG_FULL_ASSERT(PROG_FULL_ASSERT),
  .PROG_FULL_NEGATE(PROG_FULL_NEGATE), .PROG_EMPTY_ASSERT(PROG_EMPTY_ASSERT),
  .PROG_EMPTY_NEGATE(PROG_EMPTY_NEGATE)) mon (
  .hclk(hclk), .rd_clk(rd_clk), .queue_rst(queue_rst), .wr_en(wr_en), .wr_flags(wr_flags),
  .wr_count(wr_count), .rd_en(rd_en), .rdata(rdata), .rd_flags(rd_flags), .rd_count(rd_count));

`default_nettype wire

// File: tb/dcq_reader.sv
// Consumer model that pops the queue in the read domain.
`timescale 1ns/1ns
`default_nettype none

module dcq_reader
  import dcq_pkg::*;
(
  // Pace and misuse controls.
  input wire logic go,
  input wire logic rude,
  // Queue read side.
  input wire dcq_rd_flags_type rd_flags,
  output logic rd_en
);
  // Gated on empty, not the count, which can run ahead of a presentable word.
  always_comb rd_en = go && (!rd_flags.empty || rude);
endmodule : dcq_reader

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the dual-clock queue and its bus registers.
`timescale 1ns/1ns
`default_nettype none

module testbench
  import dcq_pkg::*;
;
  localparam int PFA = 12;
  logic hclk = 1'b0;
  logic rd_clk = 1'b0;
  logic queue_rst = 1'b1;
  logic hresetn = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic go = 1'b0;
  logic rude = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic rd_en, hreadyout, hresp, pend, pend_full, rpend, rpend_empty;
  logic [31:0] hrdata, rd_word;
  logic [7:0] rdata, rexp;
  logic [3:0] wr_count, rd_count;
  dcq_wr_flags_type wr_flags;
  dcq_rd_flags_type rd_flags;
  logic rd_en_ft;
  logic [7:0] rdata_ft, keep_ft;
  logic [3:0] rd_count_ft;
  dcq_rd_flags_type rd_flags_ft;
  logic [7:0] model[$];
  int seed = 17;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  int n_ft;

  initial forever #10 hclk = ~hclk;
  // Odd edge times keep the read clock from ever meeting a bus clock edge.
  initial
  begin
    #3;
    forever #8 rd_clk = ~rd_clk;
  end

  dcq_top #(.PROG_FULL_ASSERT(PFA)) dut (.hclk(hclk), .rd_clk(rd_clk), .queue_rst(queue_rst),
    .hresetn(hresetn), .wr_en(wr_en), .wdata(wdata), .wr_flags(wr_flags), .wr_count(wr_count),
    .rd_en(rd_en), .rdata(rdata), .rd_flags(rd_flags), .rd_count(rd_count), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  dcq_reader reader (.go(go), .rude(rude), .rd_flags(rd_flags), .rd_en(rd_en));
  // Second queue with fall-through, the extra synchroniser stage and dual thresholds.
  dcq_top #(.FALL_THROUGH_PRESENTATION(1'b1), .EXTRA_SYNC_STAGE(1'b1),
    .PROG_FULL_MODE(DCQ_PROG_DUAL), .PROG_EMPTY_MODE(DCQ_PROG_DUAL)) dut_ft (.hclk(hclk),
    .rd_clk(rd_clk), .queue_rst(queue_rst), .hresetn(hresetn), .wr_en(wr_en), .wdata(wdata),
    .wr_flags(), .wr_count(), .rd_en(rd_en_ft), .rdata(rdata_ft), .rd_flags(rd_flags_ft),
    .rd_count(rd_count_ft), .hsel(1'b0), .haddr(32'h0), .htrans(2'h0), .hwrite(1'b0),
    .hsize(3'h2), .hwdata(32'h0), .hready(1'b1), .hreadyout(), .hrdata(), .hresp());
  dcq_reader reader_ft (.go(go), .rude(rude), .rd_flags(rd_flags_ft), .rd_en(rd_en_ft));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic pf_exp(input int words);
    return words >= PFA;
  endfunction : pf_exp

  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= DCQ_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_word = hrdata;
  endtask : ahb

  task automatic burst(input int cnt);
    wr_en <= 1'b1;
    repeat (cnt)
    begin
      wdata <= 8'($random(seed));
      @(posedge hclk);
    end
    wr_en <= 1'b0;
  endtask : burst

  // Write-side scoreboard: flags seen at an edge answer the request of the edge before.
  always @(posedge hclk)
  begin
    if (pend)
    begin
      check("write ack", wr_flags.wr_ack, !pend_full);
      check("overflow", wr_flags.overflow, pend_full);
    end
    pend <= wr_en && !queue_rst;
    pend_full <= wr_flags.full;
    if (wr_en && !wr_flags.full && !queue_rst) model.push_back(wdata);
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      results();
    end
  end

  always @(posedge rd_clk)
  begin
    if (rpend)
    begin
      check("read valid", rd_flags.rd_valid, !rpend_empty);
      check("underflow", rd_flags.underflow, rpend_empty);
      if (!rpend_empty) check("read data", rdata, rexp);
    end
    rpend <= rd_en && !queue_rst;
    rpend_empty <= rd_flags.empty;
    if (rd_en && !rd_flags.empty && !queue_rst) rexp <= model.pop_front();
  end

  initial
  begin
    repeat (6) @(posedge hclk);
    queue_rst <= 1'b0;
    hresetn <= 1'b1;
    @(posedge hclk);
    burst(1);
    n = 0;
    n_ft = 0;
    while (rd_flags_ft.empty === 1'b1 && n_ft < 20)
    begin
      @(posedge rd_clk);
      #1;
      n_ft++;
      if (n == 0 && rd_flags.empty === 1'b0) n = n_ft;
    end
    check("empty delay", n, DCQ_BASE_SYNC_STAGES + 1);
    check("ft empty delay", n_ft, DCQ_BASE_SYNC_STAGES + 3);
    check("ft first word", rdata_ft, model[0]);
    check("ft valid", rd_flags_ft.rd_valid, 1'b1);
    $display("test crossing done");
    @(posedge hclk);
    burst(17);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    check("full", wr_flags.full, model.size() == 16);
    check("count wrap", wr_count, 4'(model.size()));
    check("prog full", wr_flags.prog_full, pf_exp(model.size()));
    ahb(1'b0, 32'h04, 32'h0);
    check("status", rd_word & 32'h0f1f, 32'h001c);
    ahb(1'b0, 32'h00, 32'h0);
    check("thr reset", rd_word, 32'h000a000c);
    ahb(1'b1, 32'h00, 32'h0009000e);
    ahb(1'b0, 32'h00, 32'h0);
    check("thr write", rd_word, 32'h0009000e);
    ahb(1'b1, 32'h00, 32'h000a000c);
    ahb(1'b0, 32'h08, 32'h0);
    check("unmapped", rd_word, 32'h0);
    $display("test fill done");
    repeat (150)
    begin
      @(posedge hclk);
      go <= 1'($random(seed));
    end
    @(posedge hclk);
    go <= 1'b1;
    while (model.size() > 0) @(posedge hclk);
    rude <= 1'b1;
    repeat (3) @(posedge hclk);
    rude <= 1'b0;
    go <= 1'b0;
    repeat (4) @(posedge hclk);
    @(negedge hclk);
    check("drained count", wr_count, 4'h0);
    check("drained full", wr_flags.full, 1'b0);
    check("read count", rd_count, 4'h0);
    check("ft read count", rd_count_ft, 4'h0);
    check("ft drained empty", rd_flags_ft.empty, 1'b1);
    $display("test drain done");
    rd_word = 32'(rdata);
    keep_ft = rdata_ft;
    @(posedge hclk);
    queue_rst <= 1'b1;
    wr_en <= 1'b1;
    repeat (6) @(posedge hclk);
    wr_en <= 1'b0;
    queue_rst <= 1'b0;
    repeat (6) @(posedge hclk);
    @(negedge hclk);
    check("rdata kept", rdata, rd_word[7:0]);
    check("ft rdata kept", rdata_ft, keep_ft);
    check("reset count", wr_count, 4'h0);
    check("reset empty", rd_flags.empty, 1'b1);
    @(posedge hclk);
    burst(1);
    @(negedge hclk);
    check("count after", wr_count, 4'h1);
    $display("test reset done");
    results();
  end
endmodule : testbench

`default_nettype wire
